// *** hw/ssl_pkg.sv ***
// Constants shared by the host-link receiver, transmitter and command sequencer.
// Assumes a single 100 MHz core clock.
package ssl_pkg;
   localparam int unsigned CLK_HZ = 100_000_000;
   localparam int unsigned CLK_PERIOD_NS = 10;
   localparam int unsigned BAUD_MIN = 300;
   localparam int unsigned BAUD_MAX = 256_000;
   localparam int PER_W = 19;
   localparam int MEAS_W = 22;
   localparam int unsigned MEAS_SHIFT = 3;
   // Longest and shortest bit periods in core cycles
   localparam logic [PER_W-1:0] BIT_CYC_MAX = PER_W'(CLK_HZ / BAUD_MIN);
   localparam logic [PER_W-1:0] BIT_CYC_MIN = PER_W'(CLK_HZ / BAUD_MAX);
   // Host reset must stay low longer than this
   localparam int unsigned RST_LOW_NS = 2000;
   localparam logic [7:0] RST_CYC =
      8'((RST_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   localparam logic [1:0] SYNC_FALLS = 2'h3;
   localparam logic [3:0] RX_LAST_BIT = 4'h8;
   localparam logic [3:0] TX_STOP_BIT = 4'h9;
   localparam logic [7:0] CHAR_SYNC = 8'h55;
   localparam logic [7:0] CHAR_ACK = 8'h06;
   localparam logic [7:0] CHAR_NAK = 8'h15;

   typedef enum logic [2:0] {
      RX_HUNT = 3'b000,
      RX_ARM = 3'b001,
      RX_MEAS = 3'b011,
      RX_SSTOP = 3'b010,
      RX_IDLE = 3'b110,
      RX_DATA = 3'b111,
      RX_STOP = 3'b101
   } ssl_rx_e;

   typedef enum logic {
      CMD_COLLECT = 1'b0,
      CMD_WAIT = 1'b1
   } ssl_cmd_e;
endpackage

// *** hw/ssl_tx_if.sv ***
// Carrier between the link sequencer and its serial transmitter.
// Assumes both ends share the core clock.
interface ssl_tx_if;
   logic start;
   logic [7:0] data;
   logic [ssl_pkg::PER_W-1:0] per;
   logic busy;
   logic line;
   modport ctl (output start, output data, output per, input busy, input line);
   modport tx (input start, input data, input per, output busy, output line);
endinterface

// *** hw/ssl_uart_tx.sv ***
// Serial transmitter: start bit, eight data bits LSB first, one stop bit.
// Assumes start is only raised while busy is low, and per is held during a frame.
module ssl_uart_tx (
   input wire logic i_core_clk,
   input wire logic i_reset_n,
   input wire logic i_ce,
   input wire logic i_clr,
   ssl_tx_if.tx t
);
   logic busy_q, busy_d;
   logic line_q, line_d;
   logic [8:0] sh_q, sh_d;
   logic [3:0] bit_q, bit_d;
   logic [ssl_pkg::PER_W-1:0] cnt_q, cnt_d;

   always_comb begin
      busy_d = busy_q;
      line_d = line_q;
      sh_d = sh_q;
      bit_d = bit_q;
      cnt_d = cnt_q;
      if (i_clr) begin
         busy_d = 1'b0;
         line_d = 1'b1;
         bit_d = 4'h0;
      end else if (!busy_q) begin
         line_d = 1'b1;
         if (t.start) begin
            busy_d = 1'b1;
            line_d = 1'b0;
            sh_d = {1'b1, t.data};
            bit_d = 4'h0;
            cnt_d = t.per - 1'b1;
         end
      end else if (cnt_q != '0) begin
         cnt_d = cnt_q - 1'b1;
      end else if (bit_q == ssl_pkg::TX_STOP_BIT) begin
         busy_d = 1'b0;
      end else begin
         line_d = sh_q[0];
         sh_d = {1'b1, sh_q[8:1]};
         bit_d = bit_q + 1'b1;
         cnt_d = t.per - 1'b1;
      end
   end

   always_ff @(posedge i_core_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         busy_q <= 1'b0;
         line_q <= 1'b1;
         sh_q <= 9'h1ff;
         bit_q <= 4'h0;
         cnt_q <= '0;
      end else if (i_ce) begin
         busy_q <= busy_d;
         line_q <= line_d;
         sh_q <= sh_d;
         bit_q <= bit_d;
         cnt_q <= cnt_d;
      end
   end

   assign t.busy = busy_q;
   assign t.line = line_q;

   AST_TX_START_LOW: assert property (@(posedge i_core_clk) disable iff (!i_reset_n)
      (i_ce && !i_clr && !busy_q && t.start) |=> (busy_q && !line_q))
      else $error("Start bit not driven low");
   AST_TX_STOP_HIGH: assert property (@(posedge i_core_clk) disable iff (!i_reset_n)
      (busy_q && bit_q == ssl_pkg::TX_STOP_BIT) |-> line_q)
      else $error("Stop bit not high");
   AST_TX_IDLE_HIGH: assert property (@(posedge i_core_clk) disable iff (!i_reset_n)
      (!busy_q && $past(!busy_q)) |-> line_q)
      else $error("Transmit line not idle high");
endmodule

// *** hw/ssl_link.sv ***
// Host serial link: reset filter, auto-baud, receiver and command sequencer.
// Assumes all pins are synchronous to i_core_clk; command decode lives outside.
module ssl_link #(
   parameter logic [ssl_pkg::PER_W-1:0] P_BIT_CYC_MAX = ssl_pkg::BIT_CYC_MAX
) (
   input wire logic i_core_clk,
   input wire logic i_reset_n,
   input wire logic i_ce,
   input wire logic i_host_reset_n,
   input wire logic i_rx,
   output logic o_tx,
   output logic o_locked,
   output logic o_rx_valid,
   output logic [7:0] o_rx_data,
   output logic [7:0] o_rx_pos,
   input wire logic i_cmd_known,
   input wire logic [7:0] i_cmd_len,
   output logic o_cmd_go,
   output logic o_rsp_ready,
   input wire logic i_stat_valid,
   input wire logic i_stat_ok,
   input wire logic i_rsp_valid,
   input wire logic [7:0] i_rsp_data,
   input wire logic i_rsp_last
);
   localparam int PW = ssl_pkg::PER_W;

   ssl_tx_if txi ();

   default clocking cb @(posedge i_core_clk);
   endclocking
   default disable iff (!i_reset_n);

   // Host reset filter; the pin is only ever read here
   logic [7:0] rcnt_q, rcnt_d;
   logic clr_q, clr_d;

   always_comb begin
      clr_d = 1'b0;
      rcnt_d = rcnt_q;
      if (i_host_reset_n) begin
         rcnt_d = 8'h00;
      end else if (rcnt_q != ssl_pkg::RST_CYC) begin
         rcnt_d = rcnt_q + 8'h01;
      end else begin
         clr_d = 1'b1;
      end
   end

   always_ff @(posedge i_core_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         rcnt_q <= 8'h00;
         clr_q <= 1'b0;
      end else if (i_ce) begin
         rcnt_q <= rcnt_d;
         clr_q <= clr_d;
      end
   end

   AST_RESET_LONG: assert property (
      (i_ce && !i_host_reset_n && rcnt_q == ssl_pkg::RST_CYC) |=> clr_q)
      else $error("Long host reset did not clear the link");
   AST_RESET_SHORT: assert property (
      (i_ce && rcnt_q != ssl_pkg::RST_CYC) |=> !clr_q)
      else $error("Link cleared before the reset was long enough");

   // Auto-baud and receiver
   ssl_pkg::ssl_rx_e rx_st_q, rx_st_d;
   logic rx_prev_q, rx_prev_d;
   logic [ssl_pkg::MEAS_W-1:0] meas_q, meas_d;
   logic [1:0] fall_q, fall_d;
   logic [PW-1:0] per_q, per_d, cnt_q, cnt_d, per_new;
   logic [3:0] bit_q, bit_d;
   logic [7:0] sh_q, sh_d;
   logic locked_q, locked_d;
   logic fell, byte_v, lock_ev;

   assign fell = rx_prev_q & ~i_rx;
   assign per_new = meas_q[ssl_pkg::MEAS_SHIFT +: PW];

   always_comb begin
      rx_st_d = rx_st_q;
      rx_prev_d = i_rx;
      meas_d = meas_q;
      fall_d = fall_q;
      per_d = per_q;
      cnt_d = cnt_q;
      bit_d = bit_q;
      sh_d = sh_q;
      locked_d = locked_q;
      byte_v = 1'b0;
      lock_ev = 1'b0;
      unique case (rx_st_q)
         ssl_pkg::RX_HUNT: begin
            if (i_rx) begin
               rx_st_d = ssl_pkg::RX_ARM;
            end
         end
         ssl_pkg::RX_ARM: begin
            if (fell) begin
               rx_st_d = ssl_pkg::RX_MEAS;
               // The fall cycle counts, so eight cells floor to exactly one period
               meas_d = {{(ssl_pkg::MEAS_W-1){1'b0}}, 1'b1};
               fall_d = 2'h0;
            end
         end
         ssl_pkg::RX_MEAS: begin
            meas_d = meas_q + 1'b1;
            if (fell) begin
               fall_d = fall_q + 2'h1;
               if (fall_q == ssl_pkg::SYNC_FALLS) begin
                  // Fifth falling edge ends eight bit cells
                  if (per_new >= ssl_pkg::BIT_CYC_MIN && per_new <= P_BIT_CYC_MAX) begin
                     rx_st_d = ssl_pkg::RX_SSTOP;
                     per_d = per_new;
                     cnt_d = per_new + (per_new >> 1);
                  end else begin
                     rx_st_d = ssl_pkg::RX_HUNT;
                  end
               end
            end else if (meas_q == {P_BIT_CYC_MAX, 3'h0}) begin
               rx_st_d = ssl_pkg::RX_HUNT;
            end
         end
         ssl_pkg::RX_SSTOP: begin
            if (cnt_q != '0) begin
               cnt_d = cnt_q - 1'b1;
            end else if (i_rx) begin
               rx_st_d = ssl_pkg::RX_IDLE;
               locked_d = 1'b1;
               lock_ev = 1'b1;
            end else begin
               rx_st_d = ssl_pkg::RX_HUNT;
            end
         end
         ssl_pkg::RX_IDLE: begin
            if (fell) begin
               rx_st_d = ssl_pkg::RX_DATA;
               cnt_d = per_q >> 1;
               bit_d = 4'h0;
            end
         end
         ssl_pkg::RX_DATA: begin
            if (cnt_q != '0) begin
               cnt_d = cnt_q - 1'b1;
            end else begin
               cnt_d = per_q - 1'b1;
               bit_d = bit_q + 4'h1;
               if (bit_q == 4'h0 && i_rx) begin
                  rx_st_d = ssl_pkg::RX_IDLE;
               end else if (bit_q != 4'h0) begin
                  sh_d = {i_rx, sh_q[7:1]};
                  if (bit_q == ssl_pkg::RX_LAST_BIT) begin
                     rx_st_d = ssl_pkg::RX_STOP;
                  end
               end
            end
         end
         ssl_pkg::RX_STOP: begin
            if (cnt_q != '0) begin
               cnt_d = cnt_q - 1'b1;
            end else begin
               rx_st_d = ssl_pkg::RX_IDLE;
               byte_v = i_rx;
            end
         end
         default: rx_st_d = ssl_pkg::RX_HUNT;
      endcase
      if (clr_q) begin
         rx_st_d = ssl_pkg::RX_HUNT;
         locked_d = 1'b0;
         byte_v = 1'b0;
         lock_ev = 1'b0;
      end
   end

   always_ff @(posedge i_core_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         rx_st_q <= ssl_pkg::RX_HUNT;
         rx_prev_q <= 1'b1;
         meas_q <= '0;
         fall_q <= 2'h0;
         per_q <= ssl_pkg::BIT_CYC_MAX;
         cnt_q <= '0;
         bit_q <= 4'h0;
         sh_q <= 8'h00;
         locked_q <= 1'b0;
      end else if (i_ce) begin
         rx_st_q <= rx_st_d;
         rx_prev_q <= rx_prev_d;
         meas_q <= meas_d;
         fall_q <= fall_d;
         per_q <= per_d;
         cnt_q <= cnt_d;
         bit_q <= bit_d;
         sh_q <= sh_d;
         locked_q <= locked_d;
      end
   end

   AST_CLEAR_UNLOCKS: assert property (
      (i_ce && clr_q) |=> (!locked_q && rx_st_q == ssl_pkg::RX_HUNT))
      else $error("Rate kept across a host reset");
   AST_PERIOD_RANGE: assert property (
      locked_q |-> (per_q >= ssl_pkg::BIT_CYC_MIN && per_q <= P_BIT_CYC_MAX))
      else $error("Locked bit period out of range");
   AST_UNLOCKED_TX_IDLE: assert property (
      !locked_q |-> o_tx)
      else $error("Transmit active before rate lock");

   // Command sequencer and reply transmitter
   ssl_pkg::ssl_cmd_e cmd_q, cmd_d;
   logic [7:0] pos_q, pos_d;
   logic rxv_q, rxv_d, go_q, go_d, rdy_q, rdy_d;
   logic [7:0] rxd_q, rxd_d;
   logic pend_v_q, pend_v_d, pend_last_q, pend_last_d, start_q, start_d;
   logic [7:0] pend_q, pend_d, txd_q, txd_d;

   always_comb begin
      cmd_d = cmd_q;
      pos_d = pos_q;
      rxv_d = 1'b0;
      rxd_d = rxd_q;
      go_d = 1'b0;
      pend_v_d = pend_v_q;
      pend_d = pend_q;
      pend_last_d = pend_last_q;
      start_d = 1'b0;
      txd_d = txd_q;
      if (pend_v_q && !txi.busy && !start_q) begin
         start_d = 1'b1;
         txd_d = pend_q;
         pend_v_d = 1'b0;
         if (pend_last_q) begin
            cmd_d = ssl_pkg::CMD_COLLECT;
         end
      end
      if (lock_ev) begin
         pend_v_d = 1'b1;
         pend_d = ssl_pkg::CHAR_ACK;
         pend_last_d = 1'b0;
      end
      if (byte_v && cmd_q == ssl_pkg::CMD_COLLECT) begin
         rxv_d = 1'b1;
         rxd_d = sh_q;
      end
      if (rxv_q) begin
         if (pos_q == 8'h00 && !i_cmd_known) begin
            pend_v_d = 1'b1;
            pend_d = ssl_pkg::CHAR_NAK;
            pend_last_d = 1'b0;
         end else if (pos_q + 8'h01 >= i_cmd_len) begin
            go_d = 1'b1;
            cmd_d = ssl_pkg::CMD_WAIT;
            pos_d = 8'h00;
         end else begin
            pos_d = pos_q + 8'h01;
         end
      end
      if (cmd_q == ssl_pkg::CMD_WAIT && rdy_q) begin
         if (i_stat_valid) begin
            pend_v_d = 1'b1;
            pend_d = i_stat_ok ? ssl_pkg::CHAR_ACK : ssl_pkg::CHAR_NAK;
            pend_last_d = 1'b1;
         end else if (i_rsp_valid) begin
            pend_v_d = 1'b1;
            pend_d = i_rsp_data;
            pend_last_d = i_rsp_last;
         end
      end
      if (clr_q) begin
         cmd_d = ssl_pkg::CMD_COLLECT;
         pos_d = 8'h00;
         rxv_d = 1'b0;
         go_d = 1'b0;
         pend_v_d = 1'b0;
         start_d = 1'b0;
      end
      rdy_d = (cmd_d == ssl_pkg::CMD_WAIT) && !pend_v_d;
   end

   always_ff @(posedge i_core_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         cmd_q <= ssl_pkg::CMD_COLLECT;
         pos_q <= 8'h00;
         rxv_q <= 1'b0;
         rxd_q <= 8'h00;
         go_q <= 1'b0;
         rdy_q <= 1'b0;
         pend_v_q <= 1'b0;
         pend_q <= 8'h00;
         pend_last_q <= 1'b0;
         start_q <= 1'b0;
         txd_q <= 8'h00;
      end else if (i_ce) begin
         cmd_q <= cmd_d;
         pos_q <= pos_d;
         rxv_q <= rxv_d;
         rxd_q <= rxd_d;
         go_q <= go_d;
         rdy_q <= rdy_d;
         pend_v_q <= pend_v_d;
         pend_q <= pend_d;
         pend_last_q <= pend_last_d;
         start_q <= start_d;
         txd_q <= txd_d;
      end
   end

   assign txi.start = start_q;
   assign txi.data = txd_q;
   assign txi.per = per_q;

   ssl_uart_tx u_tx (
      .i_core_clk(i_core_clk),
      .i_reset_n(i_reset_n),
      .i_ce(i_ce),
      .i_clr(clr_q),
      .t(txi)
   );

   assign o_tx = txi.line;
   assign o_locked = locked_q;
   assign o_rx_valid = rxv_q;
   assign o_rx_data = rxd_q;
   assign o_rx_pos = pos_q;
   assign o_cmd_go = go_q;
   assign o_rsp_ready = rdy_q;

   AST_ACK_ON_LOCK: assert property (
      (i_ce && !clr_q && rx_st_q == ssl_pkg::RX_SSTOP && cnt_q == '0 && i_rx)
      |=> (locked_q && pend_v_q && pend_q == ssl_pkg::CHAR_ACK))
      else $error("No acknowledge queued on rate lock");
   AST_UNKNOWN_NAK: assert property (
      (i_ce && !clr_q && rxv_q && pos_q == 8'h00 && !i_cmd_known)
      |=> (pend_v_q && pend_q == ssl_pkg::CHAR_NAK && cmd_q == ssl_pkg::CMD_COLLECT))
      else $error("Unknown command not answered with NAK");
   AST_STATUS_BYTE: assert property (
      (i_ce && !clr_q && cmd_q == ssl_pkg::CMD_WAIT && rdy_q && i_stat_valid)
      |=> (pend_v_q && pend_last_q && !rdy_q
           && pend_q == ($past(i_stat_ok) ? ssl_pkg::CHAR_ACK : ssl_pkg::CHAR_NAK)))
      else $error("Status byte wrong");
   AST_CMD_COMPLETE: assert property (
      (i_ce && !clr_q && rxv_q && (pos_q != 8'h00 || i_cmd_known)
       && pos_q + 8'h01 >= i_cmd_len)
      |=> (o_cmd_go && cmd_q == ssl_pkg::CMD_WAIT && pos_q == 8'h00))
      else $error("Complete command not issued");
endmodule

// *** sim/ssl_host_model.sv ***
// Host side of the serial link: UART transmitter, UART receiver, open-drain reset pin.
// Assumes one caller per direction at a time; the bench sets bit_cyc before a frame.
module ssl_host_model (
   input wire logic i_core_clk,
   input wire logic i_line_in,
   output logic o_line_out,
   output logic o_rst_oe
);
   timeunit 1ns;
   timeprecision 1ps;
   int bit_cyc = 32'h190;
   int wait_max = 32'h9c40;
   initial begin
      o_line_out = 1'b1;
      o_rst_oe = 1'b0;
   end
   // One frame LSB first; nothing is appended after a command
   task automatic send_byte(input logic [7:0] b);
      logic [9:0] frame;
      frame = {1'b1, b, 1'b0};
      for (int i = 0; i < 10; i++) begin
         @(posedge i_core_clk);
         o_line_out <= frame[i];
         repeat (bit_cyc - 1) @(posedge i_core_clk);
      end
   endtask
   // Waits for any reply latency up to wait_max, then samples mid-bit
   task automatic recv_byte(output logic [7:0] b, output logic ok);
      int n;
      ok = 1'b0;
      b = 8'h00;
      n = 0;
      @(posedge i_core_clk);
      while (i_line_in !== 1'b0 && n < wait_max) begin
         @(posedge i_core_clk);
         n++;
      end
      if (n < wait_max) begin
         repeat (bit_cyc / 2) @(posedge i_core_clk);
         ok = (i_line_in === 1'b0);
         for (int i = 0; i < 8; i++) begin
            repeat (bit_cyc) @(posedge i_core_clk);
            b[i] = i_line_in;
         end
         repeat (bit_cyc) @(posedge i_core_clk);
         ok = ok && (i_line_in === 1'b1);
      end
   endtask
   // Drives the reset pin low only, then releases it to the pull-up
   task automatic pull_reset(input int cycles);
      @(posedge i_core_clk);
      o_rst_oe <= 1'b1;
      repeat (cycles) @(posedge i_core_clk);
      o_rst_oe <= 1'b0;
   endtask
endmodule

// *** sim/serial_storage_host_link_bench.sv ***
// Self-checking bench for the host serial link with a host model on the far side.
// Assumes the link's longest bit period is shortened so bit periods stay short.
module serial_storage_host_link_bench;
   timeunit 1ns;
   timeprecision 1ps;
   localparam logic [18:0] BIT_MAX = 19'h007d0;
   logic clk = 1'b0;
   logic i_reset_n = 1'b0;
   logic i_ce = 1'b1;
   logic host_tx, rst_oe, host_rst_n, o_tx, o_locked, o_rx_valid, o_cmd_go, o_rsp_ready;
   logic [7:0] o_rx_data, o_rx_pos;
   logic i_cmd_known = 1'b1;
   logic [7:0] i_cmd_len = 8'h01;
   logic i_stat_valid = 1'b0;
   logic i_stat_ok = 1'b0;
   logic i_rsp_valid = 1'b0;
   logic [7:0] i_rsp_data = 8'h00;
   logic i_rsp_last = 1'b0;
   int mismatches = 0;
   int num_checks = 0;
   int gos = 0;
   logic [7:0] pos_q[$];
   logic [7:0] rx_bytes[$];
   logic [7:0] tx_b[2];
   logic [7:0] rx_b[2];
   always #5 clk = ~clk;
   // Open-drain pin with pull-up
   assign host_rst_n = rst_oe ? 1'b0 : 1'b1;
   ssl_link #(.P_BIT_CYC_MAX(BIT_MAX)) dut (
      .i_core_clk(clk), .i_reset_n(i_reset_n), .i_ce(i_ce), .i_host_reset_n(host_rst_n),
      .i_rx(host_tx), .o_tx(o_tx), .o_locked(o_locked), .o_rx_valid(o_rx_valid),
      .o_rx_data(o_rx_data), .o_rx_pos(o_rx_pos), .i_cmd_known(i_cmd_known),
      .i_cmd_len(i_cmd_len), .o_cmd_go(o_cmd_go), .o_rsp_ready(o_rsp_ready),
      .i_stat_valid(i_stat_valid), .i_stat_ok(i_stat_ok), .i_rsp_valid(i_rsp_valid),
      .i_rsp_data(i_rsp_data), .i_rsp_last(i_rsp_last));
   ssl_host_model host (
      .i_core_clk(clk), .i_line_in(o_tx), .o_line_out(host_tx), .o_rst_oe(rst_oe));
   always @(posedge clk) begin
      if (o_rx_valid === 1'b1) pos_q.push_back(o_rx_pos);
      if (o_rx_valid === 1'b1) rx_bytes.push_back(o_rx_data);
      if (o_cmd_go === 1'b1) gos++;
   end
   task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
      num_checks++;
      if (seen !== exp) begin
         mismatches++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic close_out();
      $display("checks %0d mismatches %0d", num_checks, mismatches);
      if (mismatches == 0 && num_checks > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask
   task automatic give_up(input string what);
      mismatches++;
      $display("CHECK FAILED %s expected done seen timeout", what);
      close_out();
   endtask
   task automatic wait_for(input int sel);
      int n;
      n = 0;
      @(posedge clk);
      while ((sel == 0 ? o_cmd_go : o_rsp_ready) !== 1'b1) begin
         if (n == 20000) give_up("handshake");
         @(posedge clk);
         n++;
      end
   endtask
   task automatic setup(input logic known, input logic [7:0] len);
      @(posedge clk);
      i_cmd_known <= known;
      i_cmd_len <= len;
      pos_q.delete();
      rx_bytes.delete();
   endtask
   // Sends nsend bytes, answers by mode (0 none, 1 status, 2 reply bytes), checks nrecv
   task automatic xfer(input int nsend, input int nrecv, input int mode, input logic ok_bit);
      logic [7:0] got;
      logic ok;
      fork
         begin
            for (int i = 0; i < nsend; i++) host.send_byte(tx_b[i]);
         end
         begin
            if (mode != 0) begin
               wait_for(0);
               if (mode == 1) begin
                  i_stat_valid <= 1'b1;
                  i_stat_ok <= ok_bit;
                  wait_for(1);
                  i_stat_valid <= 1'b0;
               end else begin
                  for (int i = 0; i < nrecv; i++) begin
                     i_rsp_valid <= 1'b1;
                     i_rsp_data <= rx_b[i];
                     i_rsp_last <= (i == nrecv - 1);
                     wait_for(1);
                  end
                  i_rsp_valid <= 1'b0;
               end
            end
         end
         begin
            for (int i = 0; i < nrecv; i++) begin
               host.recv_byte(got, ok);
               if (ok !== 1'b1) give_up("reply frame");
               check("reply byte", got, rx_b[i]);
            end
         end
      join
      repeat (host.bit_cyc) @(posedge clk);
   endtask
   task automatic sync_up();
      tx_b[0] = ssl_pkg::CHAR_SYNC;
      rx_b[0] = ssl_pkg::CHAR_ACK;
      xfer(1, 1, 0, 1'b0);
      check("locked", {7'h00, o_locked}, 8'h01);
   endtask
   // Plain one-byte command answered by a status
   task automatic plain(input logic [7:0] code, input logic good);
      int g0;
      setup(1'b1, 8'h01);
      g0 = gos;
      tx_b[0] = code;
      rx_b[0] = good ? ssl_pkg::CHAR_ACK : ssl_pkg::CHAR_NAK;
      xfer(1, 1, 1, good);
      check("go count", 8'(gos - g0), 8'h01);
   endtask
   task automatic t_idle();
      repeat (4) @(posedge clk);
      check("idle tx", {7'h00, o_tx}, 8'h01);
      check("unlocked", {7'h00, o_locked}, 8'h00);
      // Sync character faster than the top rate must be refused silently
      host.bit_cyc = 32'h12c;
      host.send_byte(ssl_pkg::CHAR_SYNC);
      repeat (4) @(posedge clk);
      check("fast sync", {7'h00, o_locked}, 8'h00);
      check("fast sync tx", {7'h00, o_tx}, 8'h01);
      host.bit_cyc = 32'h190;
      $display("test idle finished");
   endtask
   task automatic t_unknown();
      int g0;
      setup(1'b0, 8'h03);
      g0 = gos;
      tx_b[0] = 8'h7e;
      rx_b[0] = ssl_pkg::CHAR_NAK;
      xfer(1, 1, 0, 1'b0);
      check("no go", 8'(gos - g0), 8'h00);
      $display("test unknown finished");
   endtask
   task automatic t_two();
      int g0;
      setup(1'b1, 8'h02);
      g0 = gos;
      tx_b[0] = 8'h3a;
      tx_b[1] = ssl_pkg::CHAR_NAK;
      rx_b[0] = ssl_pkg::CHAR_NAK;
      xfer(2, 1, 1, 1'b0);
      check("go count", 8'(gos - g0), 8'h01);
      check("byte count", 8'(pos_q.size()), 8'h02);
      check("pos 0", pos_q[0], 8'h00);
      check("pos 1", pos_q[1], 8'h01);
      check("data count", 8'(rx_bytes.size()), 8'h02);
      check("data 0", rx_bytes[0], 8'h3a);
      check("data 1", rx_bytes[1], ssl_pkg::CHAR_NAK);
      $display("test two byte finished");
   endtask
   task automatic t_reply();
      setup(1'b1, 8'h01);
      tx_b[0] = 8'h20;
      rx_b[0] = 8'ha5;
      rx_b[1] = 8'h5a;
      xfer(1, 2, 2, 1'b0);
      $display("test reply finished");
   endtask
   task automatic t_reset();
      host.pull_reset(200);
      repeat (4) @(posedge clk);
      check("short pulse", {7'h00, o_locked}, 8'h01);
      // A long pulse while the clock enable is low must not count
      @(posedge clk);
      i_ce <= 1'b0;
      host.pull_reset(205);
      @(posedge clk);
      i_ce <= 1'b1;
      repeat (4) @(posedge clk);
      check("frozen", {7'h00, o_locked}, 8'h01);
      host.pull_reset(205);
      repeat (4) @(posedge clk);
      check("after reset", {7'h00, o_locked}, 8'h00);
      check("tx idle", {7'h00, o_tx}, 8'h01);
      host.bit_cyc = 800;
      sync_up();
      plain(8'h41, 1'b0);
      $display("test host reset finished");
   endtask
   initial begin
      repeat (16) @(posedge clk);
      i_reset_n <= 1'b1;
      t_idle();
      sync_up();
      $display("test sync finished");
      t_unknown();
      plain(8'h40, 1'b1);
      $display("test plain finished");
      t_two();
      t_reply();
      t_reset();
      close_out();
   end
endmodule
